/* File: include/pptf_pkg.sv */
// ----------------------------------------------------------------------------
// Overview of operation
// - overload held past selected time cuts port
// - double power: current limit ends after selected time
// - cut disabled: overload flag at half-limit plus 2ms
// - start-up limiting longer than selected time faults
// - one detection lasts 275 to 425 ms
// - back-off 300-500 ms, or 15-100 ms low voltage
// - detection done within 590 ms of request
// - each class event held 6.5 to 12 ms
// - each mark event held 6 to 12 ms
// - semi-auto power-on within 200 ms of detection
// - manual turn-on finished within 4 ms
// - fault shutdown waits about 1 s before retry
// - signature absent past dropout time removes power
// - signature valid only after about 15 ms present
// - single-bit shutdown gates off within 1-5 us
// - serial shutdown code decoded at 25 us bits
// - serial code shutdown 72-104 us after start fall
// - port-off command gates off within 300 us
// - reset pin low turns all gates off quickly
// - fault flagged within 500 us of turn-off
// - logic leaves power-on reset within 20 ms
// - single-bit mode cuts low-priority ports on high
// - serial mode cuts ports with priority >= code
// - cool-down precedes new detection after fault; a port-off command ends it early, a same-cycle shutdown skips it
// ----------------------------------------------------------------------------
package pptf_pkg;

  // ----------------------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------------------
  localparam int CLK_MHZ     = 10;
  localparam int TICK_US     = 100;
  localparam int TICK_CYC    = TICK_US * CLK_MHZ;
  localparam int TPM         = 1000 / TICK_US;   // ticks per millisecond
  localparam int NPORT       = 8;
  localparam int TW          = 14;

  // ----------------------------------------------------------------------------
  // millisecond timings, the arrays indexed by select field
  // ----------------------------------------------------------------------------
  localparam int OVLD_MS [4]  = '{60, 30, 120, 240};
  localparam int LIM_MS [4]   = '{60, 15, 12, 10};
  localparam int START_MS [4] = '{60, 30, 120, 120};
  localparam int MPDO_MS [4]  = '{350, 90, 175, 700};
  localparam int LIM1X_MS     = 60;
  localparam int ICUT_ADD_MS  = 2;
  localparam int DET_MS       = 350;
  localparam int BOFF_HI_MS   = 400;
  localparam int BOFF_LO_MS   = 50;
  localparam int CLE_MS       = 9;
  localparam int ME_MS        = 9;
  localparam int ED_MS        = 1000;
  localparam int MPS_MS       = 15;

  // ----------------------------------------------------------------------------
  // microsecond timings for the pins
  // ----------------------------------------------------------------------------
  localparam int OSS_DG_US    = 2;
  localparam int RST_DG_US    = 3;
  localparam int OSS_BIT_US   = 25;
  localparam int OSS_APPLY_US = 80;
  localparam int OSS_DG_CYC   = OSS_DG_US * CLK_MHZ;
  localparam int RST_DG_CYC   = RST_DG_US * CLK_MHZ;
  localparam int OSS_BIT_CYC  = OSS_BIT_US * CLK_MHZ;
  localparam int OSS_APPLY_CYC = OSS_APPLY_US * CLK_MHZ;

  // ----------------------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_TIMING = 8'h04;
  localparam logic [7:0] ADR_CMD    = 8'h08;
  localparam logic [7:0] ADR_PRIO1  = 8'h0C;
  localparam logic [7:0] ADR_PRIO3  = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_EVENT  = 8'h18;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] PRIO_RST   = 32'h0000_0000;
  localparam int CTRL_SEMI = 0;
  localparam int CTRL_OVDIS = 1;
  localparam int CTRL_DBL = 2;
  localparam int CTRL_MBIT = 3;
  localparam int CTRL_DETEN = 8;
  localparam int TM_OVLD = 0;
  localparam int TM_LIM = 2;
  localparam int TM_START = 4;
  localparam int TM_MPDO = 6;
  localparam int CMD_ON = 0;
  localparam int CMD_OFF = 8;
  localparam int CMD_DET = 16;
  localparam int EV_FAULT = 0;
  localparam int EV_OVLW = 8;
  localparam int EV_OSS = 16;

  // ----------------------------------------------------------------------------
  // synchroniser layout and states
  // ----------------------------------------------------------------------------
  localparam int SYNC_W = 2 + 6 * NPORT;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};

  typedef enum logic [7:0] {
    P_OFF = 8'h01, P_DET = 8'h02, P_BOFF = 8'h04, P_CLS = 8'h08,
    P_MARK = 8'h10, P_START = 8'h20, P_ON = 8'h40, P_COOL = 8'h80
  } pptf_port_e;

  typedef enum logic [3:0] {
    O_IDLE = 4'h1, O_START = 4'h2, O_BITS = 4'h4, O_HOLD = 4'h8
  } pptf_oss_e;

endpackage

/* File: design/pptf_core.sv */
`timescale 1ns/1ps
module pptf_core #(
  parameter int TICK_CYCLES = pptf_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins
  input  wire logic        fast_shutdown_input_i,
  input  wire logic        reset_pin_n_i,
  // per-port analog indications
  input  wire logic [7:0]  pd_valid_i,
  input  wire logic [7:0]  vdiff_high_i,
  input  wire logic [7:0]  class4_i,
  input  wire logic [7:0]  over_cut_i,
  input  wire logic [7:0]  hard_current_limit_i,
  input  wire logic [7:0]  mps_present_i,
  // per-port drive
  output logic      [7:0]  gate_on_o,
  output logic      [7:0]  detect_en_o,
  output logic      [7:0]  class_en_o,
  output logic      [7:0]  mark_en_o
);
  import pptf_pkg::*;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic [TW-1:0] ms2t(input int ms);
    ms2t = TW'(ms * TPM);
  endfunction

  function automatic logic [TW-1:0] inc_sat(input logic [TW-1:0] v, input logic en);
    inc_sat = (en && v != {TW{1'b1}}) ? v + 1'b1 : v;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    wmerge = r;
  endfunction

  // ----------------------------------------------------------------------------
  // input synchroniser, two stages for every pin
  // ----------------------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;

  // the first stage feeds only the second
  always_comb begin
    nxt_sync1 = {reset_pin_n_i, fast_shutdown_input_i, pd_valid_i, vdiff_high_i,
                 class4_i, over_cut_i, hard_current_limit_i, mps_present_i};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  logic       rpin_n, oss_lvl;
  logic [7:0] s_pdv, s_vdh, s_cl4, s_ovc, s_hard_current_limit, s_mps;
  assign rpin_n = sync2_ff[SYNC_W-1];
  assign oss_lvl = sync2_ff[SYNC_W-2];
  assign s_pdv  = sync2_ff[47:40];
  assign s_vdh  = sync2_ff[39:32];
  assign s_cl4  = sync2_ff[31:24];
  assign s_ovc  = sync2_ff[23:16];
  assign s_hard_current_limit = sync2_ff[15:8];
  assign s_mps  = sync2_ff[7:0];

  // ----------------------------------------------------------------------------
  // time base and reset pin deglitch
  // ----------------------------------------------------------------------------
  logic [15:0] tick_cnt_ff, nxt_tick_cnt;
  logic [5:0]  rdg_ff, nxt_rdg;
  logic        pin_rst_ff, nxt_pin_rst;
  logic        tick, srst;

  // one tick shared by every port timer; short pin pulses are swallowed
  always_comb begin
    tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
    nxt_tick_cnt = tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
    nxt_rdg = rdg_ff;
    nxt_pin_rst = pin_rst_ff;
    if (rpin_n) begin
      nxt_rdg = 6'h00;
      nxt_pin_rst = 1'b0;
    end else if (rdg_ff == 6'(RST_DG_CYC)) begin
      nxt_pin_rst = 1'b1;
    end else begin
      nxt_rdg = rdg_ff + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 16'h0000;
      rdg_ff <= 6'h00;
      pin_rst_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      rdg_ff <= nxt_rdg;
      pin_rst_ff <= nxt_pin_rst;
    end
  end

  // power-on reset ends with the first edge after rst_i drops
  assign srst = rst_i | pin_rst_ff;

  // ----------------------------------------------------------------------------
  // register file over wishbone
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl_ff, timing_ff, prio1_ff, prio3_ff, dat_ff;
  logic [31:0] nxt_ctrl, nxt_timing, nxt_prio1, nxt_prio3, nxt_dat;
  logic [23:0] event_ff, nxt_event;
  logic        ack_ff, nxt_ack, wr;
  logic [7:0]  cmd_on, cmd_off, cmd_det, fault_set, ovlw_set, oss_set;
  logic [7:0]  gate_ff;

  // write takes effect on the edge where ack is seen; set beats clear
  always_comb begin
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_ctrl = ctrl_ff;
    nxt_timing = timing_ff;
    nxt_prio1 = prio1_ff;
    nxt_prio3 = prio3_ff;
    nxt_event = event_ff | {oss_set, ovlw_set, fault_set};
    cmd_on = 8'h00;
    cmd_off = 8'h00;
    cmd_det = 8'h00;
    if (wr) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          nxt_ctrl = wmerge(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_FF0F;
        end
        ADR_TIMING: begin
          nxt_timing = wmerge(timing_ff, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
        end
        ADR_PRIO1: begin
          nxt_prio1 = wmerge(prio1_ff, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
        end
        ADR_PRIO3: begin
          nxt_prio3 = wmerge(prio3_ff, wb_dat_i, wb_sel_i) & 32'h00FF_FFFF;
        end
        ADR_CMD: begin
          cmd_on  = wb_sel_i[0] ? wb_dat_i[CMD_ON +: 8] : 8'h00;
          cmd_off = wb_sel_i[1] ? wb_dat_i[CMD_OFF +: 8] : 8'h00;
          cmd_det = wb_sel_i[2] ? wb_dat_i[CMD_DET +: 8] : 8'h00;
        end
        ADR_EVENT: begin
          nxt_event = (event_ff & ~24'(wmerge(32'h0000_0000, wb_dat_i, wb_sel_i)))
                      | {oss_set, ovlw_set, fault_set};
        end
        default: begin
        end
      endcase
    end
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL:   nxt_dat = ctrl_ff;
      ADR_TIMING: nxt_dat = timing_ff;
      ADR_PRIO1:  nxt_dat = prio1_ff;
      ADR_PRIO3:  nxt_dat = prio3_ff;
      ADR_STATUS: nxt_dat = {14'h0000, pin_rst_ff, oss_lvl, s_pdv, gate_ff};
      ADR_EVENT:  nxt_dat = {8'h00, event_ff};
      default:    nxt_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      ctrl_ff <= CTRL_RST;
      timing_ff <= TIMING_RST;
      prio1_ff <= PRIO_RST;
      prio3_ff <= PRIO_RST;
      event_ff <= 24'h00_0000;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      timing_ff <= nxt_timing;
      prio1_ff <= nxt_prio1;
      prio3_ff <= nxt_prio3;
      event_ff <= nxt_event;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  logic       semi, ovdis, dbl, mbit;
  logic [1:0] sel_ovld, sel_lim, sel_start, sel_mpdo;
  assign semi = ctrl_ff[CTRL_SEMI];
  assign ovdis = ctrl_ff[CTRL_OVDIS];
  assign dbl = ctrl_ff[CTRL_DBL];
  assign mbit = ctrl_ff[CTRL_MBIT];
  assign sel_ovld = timing_ff[TM_OVLD +: 2];
  assign sel_lim = timing_ff[TM_LIM +: 2];
  assign sel_start = timing_ff[TM_START +: 2];
  assign sel_mpdo = timing_ff[TM_MPDO +: 2];

  // ----------------------------------------------------------------------------
  // fast shutdown decoder
  // ----------------------------------------------------------------------------
  pptf_oss_e   oss_st_ff, nxt_oss_st;
  logic [9:0]  oss_cnt_ff, nxt_oss_cnt;
  logic [2:0]  code_ff, nxt_code;
  logic [7:0]  oss_kill;

  // start bit must outlast the deglitch; bits sampled mid-period, msb first
  always_comb begin
    nxt_oss_st = oss_st_ff;
    nxt_oss_cnt = oss_cnt_ff;
    nxt_code = code_ff;
    oss_kill = 8'h00;
    case (oss_st_ff)
      O_IDLE: begin
        nxt_oss_cnt = 10'h000;
        if (oss_lvl) begin
          nxt_oss_st = O_START;
        end
      end
      O_START: begin
        if (oss_cnt_ff != 10'(OSS_DG_CYC)) begin
          nxt_oss_cnt = oss_cnt_ff + 10'h001;
        end
        if (!oss_lvl) begin
          nxt_oss_cnt = 10'h000;
          nxt_oss_st = (mbit && oss_cnt_ff == 10'(OSS_DG_CYC)) ? O_BITS : O_IDLE;
        end else if (!mbit && oss_cnt_ff == 10'(OSS_DG_CYC - 1)) begin
          oss_kill = prio1_ff[7:0];
          nxt_oss_st = O_HOLD;
        end
      end
      O_BITS: begin
        nxt_oss_cnt = oss_cnt_ff + 10'h001;
        for (int b = 0; b < 3; b++) begin
          if (oss_cnt_ff == 10'(OSS_BIT_CYC / 2 + b * OSS_BIT_CYC)) begin
            nxt_code[2-b] = oss_lvl;
          end
        end
        if (oss_cnt_ff == 10'(OSS_APPLY_CYC)) begin
          for (int p = 0; p < NPORT; p++) begin
            oss_kill[p] = (prio3_ff[p*3 +: 3] >= code_ff);
          end
          nxt_oss_st = O_IDLE;
        end
      end
      O_HOLD: begin
        if (!oss_lvl) begin
          nxt_oss_st = O_IDLE;
        end
      end
      default: begin
        nxt_oss_st = O_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      oss_st_ff <= O_IDLE;
      oss_cnt_ff <= 10'h000;
      code_ff <= 3'h0;
    end else begin
      oss_st_ff <= nxt_oss_st;
      oss_cnt_ff <= nxt_oss_cnt;
      code_ff <= nxt_code;
    end
  end

  // ----------------------------------------------------------------------------
  // per-port sequencer and fault timers
  // ----------------------------------------------------------------------------
  pptf_port_e  st_ff [NPORT];
  pptf_port_e  nxt_st [NPORT];
  logic [TW-1:0] tmr_ff [NPORT];
  logic [TW-1:0] ovl_ff [NPORT];
  logic [TW-1:0] lim_ff [NPORT];
  logic [TW-1:0] prs_ff [NPORT];
  logic [TW-1:0] nxt_tmr [NPORT];
  logic [TW-1:0] nxt_ovl [NPORT];
  logic [TW-1:0] nxt_lim [NPORT];
  logic [TW-1:0] nxt_prs [NPORT];
  logic [7:0]  ev2_ff, warn_ff, det_ff, cls_ff, mark_ff;
  logic [7:0]  nxt_ev2, nxt_warn, nxt_gate, nxt_det, nxt_cls, nxt_mark;

  // fault paths land in cool-down unless a shutdown comes in the same cycle; cool-down blocks detection until it expires or a port-off ends it
  always_comb begin
    fault_set = 8'h00;
    ovlw_set = 8'h00;
    oss_set = 8'h00;
    nxt_ev2 = ev2_ff;
    nxt_warn = warn_ff;
    for (int p = 0; p < NPORT; p++) begin
      logic fault;
      fault = 1'b0;
      nxt_st[p] = st_ff[p];
      nxt_tmr[p] = inc_sat(tmr_ff[p], tick);
      nxt_ovl[p] = ovl_ff[p];
      nxt_lim[p] = lim_ff[p];
      nxt_prs[p] = prs_ff[p];
      case (st_ff[p])
        P_OFF: begin
          nxt_tmr[p] = '0;
          if (cmd_on[p] && !semi) begin
            nxt_st[p] = P_START;
          end else if (cmd_det[p] || (semi && ctrl_ff[CTRL_DETEN + p])) begin
            nxt_st[p] = P_DET;
          end
        end
        P_DET: begin
          if (tmr_ff[p] >= ms2t(DET_MS)) begin
            nxt_tmr[p] = '0;
            nxt_ev2[p] = 1'b0;
            if (semi && s_pdv[p]) begin
              nxt_st[p] = P_CLS;
            end else if (semi && ctrl_ff[CTRL_DETEN + p]) begin
              nxt_st[p] = P_BOFF;
            end else begin
              nxt_st[p] = P_OFF;
            end
          end
        end
        P_BOFF: begin
          if (tmr_ff[p] >= (s_vdh[p] ? ms2t(BOFF_HI_MS) : ms2t(BOFF_LO_MS))) begin
            nxt_tmr[p] = '0;
            nxt_st[p] = P_DET;
          end
        end
        P_CLS: begin
          if (tmr_ff[p] >= ms2t(CLE_MS)) begin
            nxt_tmr[p] = '0;
            nxt_st[p] = s_cl4[p] ? P_MARK : P_START;
          end
        end
        P_MARK: begin
          if (tmr_ff[p] >= ms2t(ME_MS)) begin
            nxt_tmr[p] = '0;
            nxt_st[p] = ev2_ff[p] ? P_START : P_CLS;
            nxt_ev2[p] = 1'b1;
          end
        end
        P_START: begin
          if (tmr_ff[p] >= ms2t(START_MS[sel_start])) begin
            nxt_tmr[p] = '0;
            nxt_ovl[p] = '0;
            nxt_lim[p] = '0;
            nxt_prs[p] = '0;
            if (s_hard_current_limit[p]) begin
              fault = 1'b1;
            end else begin
              nxt_st[p] = P_ON;
            end
          end
        end
        P_ON: begin
          nxt_ovl[p] = s_ovc[p] ? inc_sat(ovl_ff[p], tick) : '0;
          nxt_lim[p] = s_hard_current_limit[p] ? inc_sat(lim_ff[p], tick) : '0;
          if (!s_ovc[p]) begin
            nxt_warn[p] = 1'b0;
          end
          if (!ovdis && ovl_ff[p] >= ms2t(OVLD_MS[sel_ovld])) begin
            fault = 1'b1;
          end
          if (ovdis && !warn_ff[p] &&
              ovl_ff[p] >= ms2t(LIM_MS[sel_lim] / 2 + ICUT_ADD_MS)) begin
            ovlw_set[p] = 1'b1;
            nxt_warn[p] = 1'b1;
          end
          if (lim_ff[p] >= (dbl ? ms2t(LIM_MS[sel_lim]) : ms2t(LIM1X_MS))) begin
            fault = 1'b1;
          end
          // the absence timer restarts only once presence has qualified
          if (s_mps[p]) begin
            nxt_prs[p] = inc_sat(prs_ff[p], tick);
            nxt_tmr[p] = (prs_ff[p] >= ms2t(MPS_MS)) ? '0 : tmr_ff[p];
          end else begin
            nxt_prs[p] = '0;
          end
          if (!s_mps[p] && tmr_ff[p] >= ms2t(MPDO_MS[sel_mpdo])) begin
            nxt_st[p] = P_OFF;
          end
        end
        P_COOL: begin
          if (tmr_ff[p] >= ms2t(ED_MS)) begin
            nxt_st[p] = P_OFF;
          end
        end
        default: begin
          nxt_st[p] = P_OFF;
        end
      endcase
      if (fault) begin
        nxt_tmr[p] = '0;
        nxt_st[p] = P_COOL;
        fault_set[p] = 1'b1;
      end
      // commanded shutdowns win over any sequencing, priority shutdowns over all but cool-down
      if (cmd_off[p] || oss_kill[p]) begin
        if (st_ff[p] != P_COOL || cmd_off[p]) begin
          nxt_st[p] = P_OFF;
        end
        oss_set[p] = oss_kill[p] && (st_ff[p] == P_START || st_ff[p] == P_ON);
      end
      nxt_gate[p] = (nxt_st[p] == P_START) || (nxt_st[p] == P_ON);
      nxt_det[p] = (nxt_st[p] == P_DET);
      nxt_cls[p] = (nxt_st[p] == P_CLS);
      nxt_mark[p] = (nxt_st[p] == P_MARK);
    end
  end

  // the reset pin drops every port to off through srst
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NPORT; p++) begin
      if (srst) begin
        st_ff[p] <= P_OFF;
        tmr_ff[p] <= '0;
        ovl_ff[p] <= '0;
        lim_ff[p] <= '0;
        prs_ff[p] <= '0;
      end else begin
        st_ff[p] <= nxt_st[p];
        tmr_ff[p] <= nxt_tmr[p];
        ovl_ff[p] <= nxt_ovl[p];
        lim_ff[p] <= nxt_lim[p];
        prs_ff[p] <= nxt_prs[p];
      end
    end
    if (srst) begin
      ev2_ff <= 8'h00;
      warn_ff <= 8'h00;
      gate_ff <= 8'h00;
      det_ff <= 8'h00;
      cls_ff <= 8'h00;
      mark_ff <= 8'h00;
    end else begin
      ev2_ff <= nxt_ev2;
      warn_ff <= nxt_warn;
      gate_ff <= nxt_gate;
      det_ff <= nxt_det;
      cls_ff <= nxt_cls;
      mark_ff <= nxt_mark;
    end
  end

  assign gate_on_o = gate_ff;
  assign detect_en_o = det_ff;
  assign class_en_o = cls_ff;
  assign mark_en_o = mark_ff;

endmodule // pptf_core

/* File: verification/pptf_asserts.sv */
`timescale 1ns/1ps
module pptf_asserts
  import pptf_pkg::*;
(
  // bus side
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and port drive
  input wire logic        fast_shutdown_input_i,
  input wire logic        reset_pin_n_i,
  input wire logic [7:0]  gate_on_o,
  input wire logic [7:0]  detect_en_o
);
  logic       wr, mb_ff, nxt_mb;
  logic [7:0] p1_ff, nxt_p1, of_ff, nxt_of;
  logic [6:0] lo_ff, nxt_lo, hi_ff, nxt_hi;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------
  // shadow of mode, priority, off mask and pin runs
  // ------------------------------------------------
  assign wr = wb_cyc_i & wb_we_i & wb_ack_o;
  // a long pin reset restores defaults, so the shadow drops too
  always_comb begin
    nxt_mb = (wr && wb_adr_i == ADR_CTRL) ? wb_dat_i[CTRL_MBIT] : mb_ff & (lo_ff < 7'h28);
    nxt_p1 = (wr && wb_adr_i == ADR_PRIO1) ? wb_dat_i[7:0] : p1_ff & {8{lo_ff < 7'h28}};
    nxt_of = (wr && wb_adr_i == ADR_CMD) ? wb_dat_i[15:8] : of_ff;
    nxt_lo = reset_pin_n_i ? 7'h00 : lo_ff + 7'(lo_ff < 7'h63);
    nxt_hi = fast_shutdown_input_i ? hi_ff + 7'(hi_ff < 7'h63) : 7'h00;
  end
  // counters saturate so they never wrap into a false match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {mb_ff, p1_ff, of_ff, lo_ff, hi_ff} <= '0;
    end else begin
      {mb_ff, p1_ff, of_ff, lo_ff, hi_ff} <= {nxt_mb, nxt_p1, nxt_of, nxt_lo, nxt_hi};
    end
  end
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_ack_next: assert property (wb_cyc_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_unmap_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1C |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  chk_rel_off: assert property ($fell(rst_i) |-> gate_on_o == 8'h00)
    else $error("gate on at reset release");
  chk_pin_off: assert property (lo_ff == 7'h32 |-> gate_on_o == 8'h00)
    else $error("gate on after pin reset");
  chk_oss_low: assert property (hi_ff == 7'h32 && !mb_ff |-> (gate_on_o & p1_ff) == 8'h00)
    else $error("low priority port still on");
  chk_cmd_off: assert property (wr && wb_adr_i == ADR_CMD |-> ##[1:1000] (gate_on_o & of_ff) == 8'h00)
    else $error("port off command ignored");
  chk_det_gate: assert property ((gate_on_o & detect_en_o) == 8'h00)
    else $error("detect while powered");
  cov_write: cover property (wr);
  cov_oss: cover property (hi_ff == 7'h32);
  cov_gate: cover property ($rose(gate_on_o[0]));
endmodule // pptf_asserts
bind pptf_core pptf_asserts u_chk (.*);

/* File: verification/pptf_ctl_model.sv */
`timescale 1ns/1ps
module pptf_ctl_model
  import pptf_pkg::*;
(
  // clock in, shutdown pin out
  input wire logic clk_i,
  output logic     oss_o
);
  initial oss_o = 1'b0; // idles low, as its pull-down would
  // level held n cycles, set just after an edge
  task automatic hold(input logic v, input int n);
    @(posedge clk_i);
    oss_o <= v;
    repeat (n - 1) @(posedge clk_i);
  endtask
  // start bit, code msb first, then the idle gap
  task automatic send(input logic [2:0] c);
    hold(1'b1, OSS_BIT_CYC);
    for (int i = 2; i >= 0; i--) hold(c[i], OSS_BIT_CYC);
    hold(1'b0, 2 * OSS_BIT_CYC);
  endtask
endmodule // pptf_ctl_model

/* File: verification/pptf_core_tb_top.sv */
`timescale 1ns/1ps
module pptf_core_tb_top;
  import pptf_pkg::*;
  localparam int TK = 2;        // short tick keeps the run short
  localparam int MS = TPM * TK; // cycles per millisecond
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pin_n = 1'b1;
  logic        ack, fast_shutdown_input;
  logic [7:0]  adr = 8'h00, pdv = 8'h00, cut = 8'h00, mps = 8'h00;
  logic [7:0]  gate, det, cls, mrk;
  logic [31:0] wd = 32'h0000_0000, rd, rdat;
  int          n_errors = 0, num_checks = 0;
  always #50 clk_i = ~clk_i;
  pptf_core #(.TICK_CYCLES(TK)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .fast_shutdown_input_i(fast_shutdown_input), .reset_pin_n_i(pin_n),
    .pd_valid_i(pdv), .vdiff_high_i(8'h00), .class4_i(pdv), .over_cut_i(cut),
    .hard_current_limit_i(8'h00), .mps_present_i(mps), .gate_on_o(gate),
    .detect_en_o(det), .class_en_o(cls), .mark_en_o(mrk));
  pptf_ctl_model ctl (.clk_i(clk_i), .oss_o(fast_shutdown_input));
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rng(input string nm, input int n, input int lo, input int hi);
    chk(nm, 32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
  endtask
  // one classic cycle; the request stands until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {cyc, we, adr, wd} <= {1'b1, w, a, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 50);
    rdat = rd;
    {cyc, we} <= 2'b00;
    if (i >= 50) chk("ack", 32'h0, 32'h1);
    if (i >= 50) stop_test();
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return det[0];
      1: return cls[0];
      2: return gate[0];
      3: return gate[2];
      default: return gate[1];
    endcase
  endfunction
  // bounded wait for a level; running out ends the run
  task automatic wt(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v) begin
      @(posedge clk_i);
      n++;
      if (n > lim) chk("wait", 32'(s), 32'hFFFF);
      if (n > lim) stop_test();
    end
  endtask
  task automatic t_semi();
    int n, d;
    pdv <= 8'h01;
    bus(1'b1, ADR_CTRL, 32'h0000_0101);
    wt(0, 1'b1, 50 * MS, d);
    wt(0, 1'b0, 500 * MS, n);
    rng("det", n, 275 * MS, 425 * MS);
    rng("det_dly", n + d, 0, 590 * MS);
    wt(1, 1'b1, 10, d);
    wt(1, 1'b0, 20 * MS, n);
    rng("cls", n, 13 * MS / 2, 12 * MS);
    chk("mark", mrk[0], 1'b1);
    wt(2, 1'b1, 200 * MS, n);
    chk("pon", gate[0], 1'b1);
    repeat (80 * MS) @(posedge clk_i);
    cut <= 8'h01;
    wt(2, 1'b0, 100 * MS, n);
    rng("ovld", n, 50 * MS, 70 * MS);
    cut <= 8'h00;
    bus(1'b0, ADR_EVENT, 32'h0);
    chk("ev_flt", rdat[EV_FAULT], 1'b1);
    wt(0, 1'b1, 1300 * MS, n);
    rng("cool", n, 800 * MS - 10, 1200 * MS);
    bus(1'b1, ADR_CTRL, 32'h0000_0008);
    bus(1'b1, ADR_CMD, 32'h0000_FF00);
    $display("t_semi done");
  endtask
  // manual turn-on, then a serial code cuts ports with priority 3 and 4
  task automatic t_prio3();
    int n;
    bus(1'b1, ADR_PRIO3, 32'h0000_08D0);
    bus(1'b1, ADR_CMD, 32'h0000_000F);
    wt(3, 1'b1, 4 * MS, n);
    chk("pon4", gate[3:0], 4'hF);
    fork
      ctl.send(3'h3);
      wt(3, 1'b0, 1400, n);
    join
    rng("oss3", n, 970, 1300);
    chk("prio3", gate[3:0], 4'h3);
    $display("t_prio3 done");
  endtask
  task automatic t_single();
    int n;
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    bus(1'b1, ADR_PRIO1, 32'h0000_0001);
    fork
      ctl.hold(1'b1, 100);
      wt(2, 1'b0, 60, n);
    join
    rng("oss1", n, 10, 52);
    chk("oss1_hi", gate[1], 1'b1);
    ctl.hold(1'b0, 10);
    $display("t_single done");
  endtask
  // off command, unmapped read, then short and long pin resets
  task automatic t_off_pin();
    int n;
    bus(1'b1, ADR_CMD, 32'h0000_0200);
    wt(4, 1'b0, 3000, n);
    chk("off", gate[1], 1'b0);
    bus(1'b0, 8'h1C, 32'h0);
    chk("unmap", rdat, 32'h0);
    bus(1'b1, ADR_CMD, 32'h0000_0003);
    wt(4, 1'b1, 4 * MS, n);
    pin_n <= 1'b0;
    repeat (20) @(posedge clk_i);
    pin_n <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("glitch", gate[1:0], 2'h3);
    pin_n <= 1'b0;
    wt(2, 1'b0, 50, n);
    chk("pin_off", gate[1:0], 2'h0);
    repeat (20) @(posedge clk_i);
    pin_n <= 1'b1;
    $display("t_off_pin done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    mps <= 8'hFF;
    t_semi();
    t_prio3();
    t_single();
    t_off_pin();
    stop_test();
  end
endmodule // pptf_core_tb_top
